/* File: src/adc_serial_output_formatter.sv */
// Purpose: slave-side serial sequencer and output formatter of a 12-bit converter
// Assumes: cs_n, sclk and din are synchronous to ref_clk and slower than it
// Notes: sclk edges are found by comparing with the previous sample
`timescale 1ns/1ps

module adc_serial_output_formatter
  import asof_pkg::*;
#(
  parameter int RES_BITS = ASOF_RES_BITS
)(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // serial link from the host
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // serial data pin, two-signal form: value and output enable
  output logic dout,
  output logic dout_oe,
  // shutdown status
  output logic shutdown_indicator_n,
  output logic shutdown_active,
  // converter core
  input wire logic [RES_BITS-1:0] conv_code,
  output logic conv_start,
  output logic [3:0] mux_addr,
  output logic polarity_select,
  output logic single_order_select,
  output logic power_keep_select
);

  localparam int POS_LAST = 2 * RES_BITS;
  localparam int PW = $clog2(POS_LAST + 1);
  localparam logic [PW-1:0] POS_MAX = PW'(POS_LAST);
  localparam logic [2:0] CFG_LAST = 3'(ASOF_CFG_BITS - 1);

  // ==========================================================
  // elaboration checks
  generate
    if (RES_BITS < 2 || RES_BITS != $bits(BIPOLAR_FLIP))
    begin : g_bad_res
      $error("result width must match the bipolar flip constant");
    end
    if (ASOF_CFG_BITS > 8)
    begin : g_bad_cfg
      $error("input word longer than the bit counter");
    end
  endgenerate

  // ==========================================================
  // declarations
  asof_state_t state_q;
  logic sclk_q;
  logic cs_n_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cfg_done;
  logic [2:0] cfg_cnt_q;
  logic [ASOF_CFG_BITS-1:0] cfg_word_q;
  logic [ASOF_CFG_BITS-1:0] cfg_word_d;
  logic [RES_BITS-1:0] result_q;
  logic [PW-1:0] pos_q;
  logic shutdown_q;
  logic sdn_n_q;
  logic dout_q;
  logic dout_oe_q;
  logic conv_start_q;
  logic pol_q;
  logic order_q;
  logic pwr_q;
  logic [3:0] mux_q;

  asof_fmt_if #(.RES_BITS(RES_BITS), .PW(PW)) fmt_bus ();

  // ==========================================================
  // edge detection of the link pins
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sclk_q <= RST_SCLK;
      cs_n_q <= RST_CS_N;
    end
    else if (clk_en)
    begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
    end
  end

  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign cs_fall = ~cs_n & cs_n_q;

  // ==========================================================
  // sequencer
  assign cfg_done = (state_q == ST_CFG) && sclk_rise && (cfg_cnt_q == CFG_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_HUNT;
    end
    else if (clk_en)
    begin
      if (cs_n)
      begin
        state_q <= ST_HUNT;
      end
      else
      begin
        unique case (state_q)
          ST_HUNT:
          begin
            if (sclk_rise && din)
            begin
              state_q <= ST_CFG;
            end
          end
          ST_CFG:
          begin
            if (cfg_done)
            begin
              state_q <= ST_SEND;
            end
          end
          ST_SEND:
          begin
            state_q <= ST_SEND;
          end
          default:
          begin
            state_q <= ST_HUNT;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // input word capture
  assign cfg_word_d = {cfg_word_q[ASOF_CFG_BITS-2:0], din};

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cfg_cnt_q <= 3'h0;
      cfg_word_q <= '0;
    end
    else if (clk_en)
    begin
      if (cs_n || state_q == ST_HUNT)
      begin
        cfg_cnt_q <= 3'h0;
      end
      else if (state_q == ST_CFG && sclk_rise)
      begin
        cfg_cnt_q <= cfg_cnt_q + 3'h1;
        cfg_word_q <= cfg_word_d;
      end
    end
  end

  // ==========================================================
  // option registers, loaded when the word completes
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pol_q <= RST_POL;
      order_q <= RST_ORDER;
      pwr_q <= RST_PWR;
      mux_q <= RST_MUX;
    end
    else if (clk_en && cfg_done)
    begin
      pol_q <= cfg_word_d[CFG_POL_POS];
      order_q <= cfg_word_d[CFG_ORDER_POS];
      pwr_q <= cfg_word_d[CFG_PWR_POS];
      mux_q <= cfg_word_d[CFG_MUX_HI:CFG_MUX_LO];
    end
  end

  // ==========================================================
  // conversion request and result capture
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      conv_start_q <= 1'h0;
      result_q <= '0;
    end
    else if (clk_en)
    begin
      conv_start_q <= cfg_done && cfg_word_d[CFG_PWR_POS];
      if (cfg_done)
      begin
        if (cfg_word_d[CFG_POL_POS])
        begin
          result_q <= conv_code;
        end
        else
        begin
          result_q <= conv_code ^ BIPOLAR_FLIP;
        end
      end
    end
  end

  // ==========================================================
  // power shutdown flag and indicator
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      shutdown_q <= RST_SDN;
      sdn_n_q <= RST_SDN_N;
    end
    else if (clk_en)
    begin
      if (cfg_done && !cfg_word_d[CFG_PWR_POS])
      begin
        shutdown_q <= 1'h1;
        sdn_n_q <= 1'h0;
      end
      else if (cs_fall)
      begin
        shutdown_q <= 1'h0;
        sdn_n_q <= 1'h1;
      end
    end
  end

  // ==========================================================
  // output position counter
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pos_q <= '0;
    end
    else if (clk_en)
    begin
      if (cs_n || cfg_done)
      begin
        pos_q <= '0;
      end
      else if (state_q == ST_SEND && sclk_fall && pos_q != POS_MAX)
      begin
        pos_q <= pos_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // bit selection
  assign fmt_bus.pos = pos_q;
  assign fmt_bus.result = result_q;
  assign fmt_bus.bipolar = ~pol_q;
  assign fmt_bus.single_order = order_q;
  assign fmt_bus.shutdown = shutdown_q;

  asof_bit_select #(
    .RES_BITS(RES_BITS),
    .PW(PW)
  ) u_bit_select (
    .fb(fmt_bus.fmt)
  );

  // ==========================================================
  // serial output pin
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dout_q <= RST_DOUT;
      dout_oe_q <= RST_DOUT_OE;
    end
    else if (clk_en)
    begin
      if (cs_n)
      begin
        dout_q <= RST_DOUT;
        dout_oe_q <= RST_DOUT_OE;
      end
      else if (state_q == ST_SEND && sclk_fall)
      begin
        dout_q <= fmt_bus.bit_out;
        dout_oe_q <= 1'h1;
      end
    end
  end

  // ==========================================================
  // outputs
  assign dout = dout_q;
  assign dout_oe = dout_oe_q;
  assign shutdown_indicator_n = sdn_n_q;
  assign shutdown_active = shutdown_q;
  assign conv_start = conv_start_q;
  assign mux_addr = mux_q;
  assign polarity_select = pol_q;
  assign single_order_select = order_q;
  assign power_keep_select = pwr_q;

endmodule // adc_serial_output_formatter

/* File: src/asof_pkg.sv */
// Purpose: shared constants and types of the serial output formatter
// Assumes: one 7-bit input word after the start bit, 12-bit result
// Notes: field positions index the captured input word, first bit in the top position
package asof_pkg;

  // ==========================================================
  // sizes
  localparam int ASOF_RES_BITS = 12;
  localparam int ASOF_CFG_BITS = 7;

  // ==========================================================
  // input word field positions (first received bit is bit 6)
  localparam int CFG_SGL_POS = 6;
  localparam int CFG_ODD_POS = 5;
  localparam int CFG_SEL_HI_POS = 4;
  localparam int CFG_SEL_LO_POS = 3;
  localparam int CFG_POL_POS = 2;
  localparam int CFG_ORDER_POS = 1;
  localparam int CFG_PWR_POS = 0;
  localparam int CFG_MUX_HI = CFG_SGL_POS;
  localparam int CFG_MUX_LO = CFG_SEL_LO_POS;

  // ==========================================================
  // output stream positions
  localparam int POS_NULL = 0;

  // ==========================================================
  // reset values
  localparam logic RST_DOUT = 1'h0;
  localparam logic RST_DOUT_OE = 1'h0;
  localparam logic RST_SDN_N = 1'h1;
  localparam logic RST_SDN = 1'h0;
  localparam logic RST_SCLK = 1'h0;
  localparam logic RST_CS_N = 1'h1;
  localparam logic RST_POL = 1'h1;
  localparam logic RST_ORDER = 1'h1;
  localparam logic RST_PWR = 1'h1;
  localparam logic [3:0] RST_MUX = 4'h0;

  // ==========================================================
  // code conversion: offset binary to two's complement flips the top bit
  localparam logic [ASOF_RES_BITS-1:0] BIPOLAR_FLIP = 12'h800;

  // ==========================================================
  // serial sequencer states
  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_CFG  = 3'b010,
    ST_SEND = 3'b100
  } asof_state_t;

endpackage

/* File: src/asof_fmt_if.sv */
// Purpose: carries the output position and options to the bit selector
// Assumes: selector is purely combinational
// Notes: ctl side drives the position, fmt side answers with the bit
`timescale 1ns/1ps
interface asof_fmt_if #(
  parameter int RES_BITS = 12,
  parameter int PW = 5
);
  logic [PW-1:0] pos;
  logic [RES_BITS-1:0] result;
  logic bipolar;
  logic single_order;
  logic shutdown;
  logic bit_out;

  modport ctl (
    output pos,
    output result,
    output bipolar,
    output single_order,
    output shutdown,
    input bit_out
  );

  modport fmt (
    input pos,
    input result,
    input bipolar,
    input single_order,
    input shutdown,
    output bit_out
  );
endinterface

/* File: src/asof_bit_select.sv */
// Purpose: picks the serial output bit for a position of the result stream
// Assumes: position 0 is the null bit, 1..R the msb-first word
// Notes: positions R+1..2R-1 repeat the word lsb-first starting at bit 1
`timescale 1ns/1ps
module asof_bit_select
  import asof_pkg::*;
#(
  parameter int RES_BITS = ASOF_RES_BITS,
  parameter int PW = 5
)(
  // formatter side
  asof_fmt_if.fmt fb
);

  function automatic logic pick_bit(
    input logic [PW-1:0] p,
    input logic [RES_BITS-1:0] r,
    input logic bip,
    input logic one_order,
    input logic sdn
  );
    int pi;
    logic b;
    pi = int'(p);
    b = 1'b0;
    if (pi == POS_NULL)
    begin
      b = 1'b0;
    end
    else if (sdn)
    begin
      b = (pi <= RES_BITS);
    end
    else if (pi <= RES_BITS)
    begin
      b = r[RES_BITS - pi];
    end
    else if (one_order)
    begin
      b = 1'b0;
    end
    else if (pi <= 2 * RES_BITS - 1)
    begin
      b = r[pi - RES_BITS];
    end
    else
    begin
      b = bip ? r[RES_BITS-1] : 1'b0;
    end
    return b;
  endfunction

  assign fb.bit_out = pick_bit(fb.pos, fb.result, fb.bipolar, fb.single_order, fb.shutdown);

endmodule // asof_bit_select

/* File: verification/asof_fmt_sva.sv */
// Purpose: port-level assertions of the serial output formatter
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module asof_fmt_sva #(
  parameter int RES_BITS = 12
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  // status and options
  input wire logic shutdown_indicator_n,
  input wire logic shutdown_active,
  input wire logic conv_start,
  input wire logic polarity_select,
  input wire logic power_keep_select
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  AST_DESELECT_HIGHZ: assert property (cs_n && $past(cs_n) |=> !dout_oe)
    else $error("output driven while deselected");
  AST_IND_PAIR: assert property (shutdown_indicator_n != shutdown_active)
    else $error("shutdown flags disagree");
  AST_FALL_EDGE: assert property ($changed(dout) && dout_oe && $past(dout_oe)
    |-> $past(!sclk) && $past(sclk, 2))
    else $error("output changed away from a falling clock");
  AST_NULL_FIRST: assert property ($rose(dout_oe) |-> !dout)
    else $error("first output bit not null");
  AST_OE_START: assert property ($rose(dout_oe) |-> $past(!sclk) && !$past(cs_n))
    else $error("output enabled without a falling clock");
  AST_SDN_HOLD: assert property ($fell(shutdown_active) |-> !cs_n &&
    ($past(cs_n) || $past(cs_n, 2) || $past(cs_n, 3) || $past(cs_n, 4)))
    else $error("shutdown left outside a new select cycle");
  AST_WORD_LOCK: assert property (!cs_n && $past(!cs_n) && dout_oe
    |-> $stable(polarity_select) && $stable(power_keep_select))
    else $error("options changed during output");
  AST_SDN_CAUSE: assert property ($rose(shutdown_active) |-> !power_keep_select)
    else $error("shutdown without power bit zero");
  AST_CONV_CAUSE: assert property (conv_start |-> power_keep_select && !shutdown_active)
    else $error("conversion started in shutdown");

  COV_CONV: cover property (conv_start);
  COV_SDN: cover property ($rose(shutdown_active));
  COV_OUT: cover property ($rose(dout_oe));
endmodule // asof_fmt_sva

bind adc_serial_output_formatter asof_fmt_sva #(.RES_BITS(RES_BITS)) i_asof_fmt_sva (
  .ref_clk, .nrst, .cs_n, .sclk, .dout, .dout_oe, .shutdown_indicator_n,
  .shutdown_active, .conv_start, .polarity_select, .power_keep_select);

/* File: verification/asof_host_model.sv */
// Purpose: host side of the serial link, built from plain port lines
// Assumes: each clock level lasts three ref_clk cycles
// Notes: rx collects output bits, x where the output is not enabled
`timescale 1ns/1ps
module asof_host_model (
  // clock
  input wire logic ref_clk,
  // link
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [24:0] rx;

  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
    rx = '0;
  end

  task automatic half(input logic s);
    sclk = s;
    repeat (3) @(posedge ref_clk);
    #2;
  endtask

  // ==========================================================
  // one frame: leading zeros, start bit, word, then nread output bits
  task automatic frame(input logic [6:0] w, input int lead, input int nread);
    int i;
    cs_n = 1'h0;
    for (i = 0; i < lead + 8; i++)
    begin
      din = (i < lead) ? 1'h0 : (i == lead) ? 1'h1 : w[lead + 7 - i];
      half(1'h0);
      half(1'h1);
    end
    for (i = 0; i < nread; i++)
    begin
      din = i[0];
      half(1'h0);
      rx = {rx[23:0], dout_oe ? dout : 1'hx};
      half(1'h1);
    end
    half(1'h0);
    cs_n = 1'h1;
    din = 1'h0;
    half(1'h0);
  endtask
endmodule // asof_host_model

/* File: verification/adc_serial_output_formatter_tb_top.sv */
// Purpose: self-checking bench of the serial output formatter
// Assumes: host model drives the link, bench drives the converter code
// Notes: each frame sent through run is compared with a stream worked out from the options
`timescale 1ns/1ps
module adc_serial_output_formatter_tb_top;
  import asof_pkg::*;
  logic ref_clk, nrst, clk_en, cs_n, sclk, din, dout, dout_oe;
  logic shutdown_indicator_n, shutdown_active, conv_start;
  logic polarity_select, single_order_select, power_keep_select;
  logic [11:0] conv_code;
  logic [3:0] mux_addr;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;

  adc_serial_output_formatter i_adc_serial_output_formatter (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe(dout_oe),
    .shutdown_indicator_n(shutdown_indicator_n), .shutdown_active(shutdown_active),
    .conv_code(conv_code), .conv_start(conv_start), .mux_addr(mux_addr),
    .polarity_select(polarity_select), .single_order_select(single_order_select),
    .power_keep_select(power_keep_select));

  asof_host_model i_asof_host_model (
    .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  initial
  begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (conv_start === 1'h1)
      starts++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [24:0] exp_of(input logic [6:0] w, input logic [11:0] c);
    logic [11:0] r;
    logic [10:0] rv;
    int k;
    r = w[2] ? c : c ^ 12'h800;
    for (k = 0; k < 11; k++)
      rv[10 - k] = r[k + 1];
    if (!w[0])
      return {1'h0, 12'hfff, 12'h000};
    if (w[1])
      return {1'h0, r, 12'h000};
    return {1'h0, r, rv, ~w[2] & r[11]};
  endfunction

  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic run(input logic [6:0] w, input logic [11:0] c, input int lead);
    conv_code = c;
    i_asof_host_model.frame(w, lead, 25);
    chk(i_asof_host_model.rx, exp_of(w, c), "serial stream");
    chk({24'h0, dout_oe}, 25'h0, "output not released");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_unipolar();
    run(7'h5f, 12'hffe, 3);
    chk({21'h0, mux_addr}, 25'hb, "mux address");
    run(7'h5f, 12'h000, 0);
  endtask

  task automatic t_orders();
    run(7'h21, 12'h000, 1);
    run(7'h23, 12'hffe, 0);
    chk({22'h0, polarity_select, single_order_select, power_keep_select},
      25'h3, "option outputs");
    run(7'h25, 12'h5a3, 2);
  endtask

  task automatic t_shutdown();
    int s;
    s = starts;
    run(7'h7e, 12'h123, 0);
    chk({23'h0, shutdown_indicator_n, shutdown_active}, 25'h1, "indicator set");
    chk({22'h0, polarity_select, single_order_select, power_keep_select},
      25'h6, "shutdown options");
    // a whole frame with the enable low must leave every flop untouched
    clk_en = 1'h0;
    i_asof_host_model.frame(7'h5f, 0, 25);
    clk_en = 1'h1;
    chk(i_asof_host_model.rx, {25{1'hx}}, "output while frozen");
    chk({23'h0, shutdown_indicator_n, shutdown_active}, 25'h1, "indicator frozen");
    run(7'h5f, 12'h456, 0);
    chk({23'h0, shutdown_indicator_n, shutdown_active}, 25'h2, "indicator clear");
    chk(25'(starts - s), 25'h1, "conversion count");
  endtask

  task automatic t_bytes();
    // cut frame first: select high mid-result must leave a clean start behind
    i_asof_host_model.frame(7'h21, 0, 6);
    chk({24'h0, dout_oe}, 25'h0, "cut frame released");
    // three leading zeros make 24 clocks: null lands just before the nibble
    conv_code = 12'h9c5;
    i_asof_host_model.frame(7'h5f, 3, 13);
    chk({12'h0, i_asof_host_model.rx[12:0]}, {13'h0, 12'h9c5}, "byte read");
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    nrst = 1'h0;
    clk_en = 1'h1;
    conv_code = 12'h000;
    repeat (12) @(posedge ref_clk);
    #2;
    nrst = 1'h1;
    repeat (2) @(posedge ref_clk);
    #2;
    t_unipolar();
    t_orders();
    t_shutdown();
    t_bytes();
    end_of_test();
  end
endmodule // adc_serial_output_formatter_tb_top
